//--- sadc_defines.svh
`ifndef SADC_DEFINES_SVH
`define SADC_DEFINES_SVH

// ==========================================================
// Result format
`define SADC_RES_BITS 12
`define SADC_FIFO_DEPTH 8

// ==========================================================
// Link edge numbering, edge 1 is the first SCLK rise of a frame
`define SADC_MSB_EDGE 4'h3
`define SADC_LSB_EDGE 4'he
`define SADC_EDGE_SAT 4'hf
`define SADC_EDGE_ONE 4'h1

// ==========================================================
// Timing figures
`define SADC_MCLK_MHZ 100
`define SADC_TACQ_NS 468
`define SADC_TACQ_CYC ((`SADC_TACQ_NS * `SADC_MCLK_MHZ + 999) / 1000)
`define SADC_SCLK_MAX_KHZ 6400

`endif

//--- sadc_pkg.sv
package sadc_pkg;

	// ==========================================================
	// Shared types
	typedef logic [11:0] sadcSample_t;

	typedef enum logic [1:0] {
		FRAME_IDLE,
		FRAME_LOAD,
		FRAME_BUSY
	} sadcFrame_e;

endpackage

//--- sadc_fifo_if.sv
`timescale 1ns/1ps

// Sample path between the readout core and its buffer
interface sadc_fifo_if;
	sadc_pkg::sadcSample_t inData;
	logic inValid;
	logic inReady;
	sadc_pkg::sadcSample_t outData;
	logic outValid;
	logic outReady;

	modport fifo (
		input inData,
		input inValid,
		output inReady,
		output outData,
		output outValid,
		input outReady
	);

	modport user (
		output inData,
		output inValid,
		input inReady,
		input outData,
		input outValid,
		output outReady
	);
endinterface

//--- sadc_fifo.sv
`timescale 1ns/1ps

// Synchronous FIFO; outData is registered and valid the cycle after a pop
module sadc_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic nrst,
	sadc_fifo_if.fifo port
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [WIDTH-1:0] mem_nxt [DEPTH];
	logic [AW:0] wrPtr_r;
	logic [AW:0] wrPtr_nxt;
	logic [AW:0] rdPtr_r;
	logic [AW:0] rdPtr_nxt;
	logic [WIDTH-1:0] data_r;
	logic [WIDTH-1:0] data_nxt;
	logic full;
	logic empty;
	logic push;
	logic pop;

	// ==========================================================
	// Flags and handshakes
	assign empty = (wrPtr_r == rdPtr_r);
	assign full = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
	assign port.inReady = !full;
	assign port.outValid = !empty;
	assign push = port.inValid && !full;
	assign pop = port.outReady && !empty;
	assign port.outData = data_r;

	// Next pointers, storage and read register
	always_comb begin
		mem_nxt = mem_r;
		wrPtr_nxt = wrPtr_r;
		rdPtr_nxt = rdPtr_r;
		data_nxt = data_r;
		if (push) begin
			mem_nxt[wrPtr_r[AW-1:0]] = port.inData;
			wrPtr_nxt = wrPtr_r + 1'b1;
		end
		if (pop) begin
			data_nxt = mem_r[rdPtr_r[AW-1:0]];
			rdPtr_nxt = rdPtr_r + 1'b1;
		end
	end

	// Register stage
	always_ff @(posedge mclk) begin
		mem_r <= mem_nxt;
		if (!nrst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			data_r <= '0;
		end else begin
			wrPtr_r <= wrPtr_nxt;
			rdPtr_r <= rdPtr_nxt;
			data_r <= data_nxt;
		end
	end

endmodule

//--- sadc_readout.sv
// Function
// - Select falling edge starts a fresh conversion.
// - Select going low switches track/hold from acquire to hold.
// - Conversion complete returns track/hold to acquisition.
// - Serial output changes only on SCLK rising edges.
// - Serial output is high impedance while select is high.
// - Each conversion yields a 12-bit result.
// - Result is straight unipolar binary.
// - Three zero bits first, then result bits MSB first.
// - SCLK paces conversion and shifting; host keeps it within limit. The test host model runs SCLK at a 12 ns period.
// - Power-down low puts the device into shutdown.
// - Power-down high means normal operation.
// - Internal reference is off throughout shutdown.
// - Select fall enables output driving low, conversion in progress.
// - MSB appears on third SCLK rise; host gives fifteen rises. The test host model gives sixteen rises in a full frame.
// - Extra SCLK rises give zeros and do not disturb conversion.
`timescale 1ns/1ps
`include "sadc_defines.svh"

module sadc_readout (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic sclk,
	input wire logic convSelectN,
	input wire logic power_down_n,
	input wire sadc_pkg::sadcSample_t analog_input,
	input wire logic analogInputValid,
	output logic analogInputReady,
	output logic doutData,
	output logic doutOe,
	output logic hold_capacitor,
	output logic refEnable,
	output logic shutdownActive,
	output logic acquireSettled,
	output logic sampleMissed
);

	sadc_fifo_if fifoPort ();

	// ==========================================================
	// Sample buffer
	sadc_fifo #(
		.WIDTH(`SADC_RES_BITS),
		.DEPTH(`SADC_FIFO_DEPTH)
	) uFifo (
		.mclk(mclk),
		.nrst(nrst),
		.port(fifoPort.fifo)
	);

	// Source side of the buffer; back-pressure goes straight out
	assign fifoPort.inData = analog_input;
	assign fifoPort.inValid = analogInputValid;
	assign analogInputReady = fifoPort.inReady;

	// ==========================================================
	// Pin synchronisers on the system clock
	logic selMeta_r;
	logic selMeta_nxt;
	logic selSync_r;
	logic selSync_nxt;
	logic selLast_r;
	logic selLast_nxt;
	logic pdMeta_r;
	logic pdMeta_nxt;
	logic pdSync_r;
	logic pdSync_nxt;
	logic selFall;
	logic selHigh;

	// Two flops each, then one more for edge detect
	always_comb begin
		selMeta_nxt = convSelectN;
		selSync_nxt = selMeta_r;
		selLast_nxt = selSync_r;
		pdMeta_nxt = power_down_n;
		pdSync_nxt = pdMeta_r;
	end

	// Select idles high, power-down idles in shutdown
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			selMeta_r <= 1'b1;
			selSync_r <= 1'b1;
			selLast_r <= 1'b1;
			pdMeta_r <= 1'b0;
			pdSync_r <= 1'b0;
		end else begin
			selMeta_r <= selMeta_nxt;
			selSync_r <= selSync_nxt;
			selLast_r <= selLast_nxt;
			pdMeta_r <= pdMeta_nxt;
			pdSync_r <= pdSync_nxt;
		end
	end

	assign selFall = selLast_r && !selSync_r;
	assign selHigh = selSync_r;

	// ==========================================================
	// Power mode
	// Shutdown when power-down is low, normal when high
	assign shutdownActive = !pdSync_r;
	// Reference follows the mode directly
	assign refEnable = pdSync_r;

	// ==========================================================
	// Frame control on the system clock
	sadc_pkg::sadcFrame_e frame_r;
	sadc_pkg::sadcFrame_e frame_nxt;
	sadc_pkg::sadcSample_t heldSample_r;
	sadc_pkg::sadcSample_t heldSample_nxt;
	logic popReq;
	logic missed_r;
	logic missed_nxt;

	// Pop one buffered sample per started conversion
	always_comb begin
		frame_nxt = frame_r;
		heldSample_nxt = heldSample_r;
		missed_nxt = missed_r;
		popReq = 1'b0;
		unique case (frame_r)
			sadc_pkg::FRAME_IDLE: begin
				if (selFall && pdSync_r) begin
					popReq = fifoPort.outValid;
					missed_nxt = !fifoPort.outValid;
					frame_nxt = fifoPort.outValid ? sadc_pkg::FRAME_LOAD
						: sadc_pkg::FRAME_BUSY;
				end
			end
			sadc_pkg::FRAME_LOAD: begin
				heldSample_nxt = fifoPort.outData;
				frame_nxt = sadc_pkg::FRAME_BUSY;
			end
			sadc_pkg::FRAME_BUSY: begin
				if (selHigh) begin
					frame_nxt = sadc_pkg::FRAME_IDLE;
				end
			end
		endcase
	end

	// Frame state register
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			frame_r <= sadc_pkg::FRAME_IDLE;
			heldSample_r <= '0;
			missed_r <= 1'b0;
		end else begin
			frame_r <= frame_nxt;
			heldSample_r <= heldSample_nxt;
			missed_r <= missed_nxt;
		end
	end

	assign fifoPort.outReady = popReq;
	assign sampleMissed = missed_r;

	// ==========================================================
	// Acquisition time monitor
	logic [5:0] acqCnt_r;
	logic [5:0] acqCnt_nxt;

	// Counts cycles since select rose, saturating at the acquisition time
	always_comb begin
		acqCnt_nxt = acqCnt_r;
		if (!selHigh) begin
			acqCnt_nxt = '0;
		end else if (acqCnt_r != 6'(`SADC_TACQ_CYC)) begin
			acqCnt_nxt = acqCnt_r + 6'h01;
		end
	end

	// Counter register, settled after reset
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			acqCnt_r <= 6'(`SADC_TACQ_CYC);
		end else begin
			acqCnt_r <= acqCnt_nxt;
		end
	end

	// Tells the host side a new start is safe, also after an abort
	assign acquireSettled = (acqCnt_r == 6'(`SADC_TACQ_CYC));

	// ==========================================================
	// Successive approximation on the link clock
	logic [3:0] edgeCnt_r;
	logic [3:0] edgeCnt_nxt;
	sadc_pkg::sadcSample_t holdCap_r;
	sadc_pkg::sadcSample_t holdCap_nxt;
	sadc_pkg::sadcSample_t sarCode_r;
	sadc_pkg::sadcSample_t sarCode_nxt;
	logic dout_r;
	logic dout_nxt;
	logic convDone_r;
	logic convDone_nxt;
	logic inResult;
	logic [3:0] bitIdx;
	sadc_pkg::sadcSample_t cmpSrc;
	sadc_pkg::sadcSample_t sarBase;
	sadc_pkg::sadcSample_t trialCode;
	logic decided;

	// One result bit decided and shifted per SCLK rise from edge 3 to edge 14; other rises shift zeros
	always_comb begin
		edgeCnt_nxt = edgeCnt_r;
		if (edgeCnt_r != `SADC_EDGE_SAT) begin
			edgeCnt_nxt = edgeCnt_r + `SADC_EDGE_ONE;
		end
		inResult = (edgeCnt_nxt >= `SADC_MSB_EDGE) && (edgeCnt_nxt <= `SADC_LSB_EDGE);
		bitIdx = `SADC_LSB_EDGE - edgeCnt_nxt;
		// Sample is taken over on the MSB edge, long after it settled
		cmpSrc = (edgeCnt_nxt == `SADC_MSB_EDGE) ? heldSample_r : holdCap_r;
		sarBase = (edgeCnt_nxt == `SADC_MSB_EDGE) ? '0 : sarCode_r;
		trialCode = sarBase | (12'h001 << bitIdx);
		// Straight binary compare against the trial code
		decided = (cmpSrc >= trialCode);
		holdCap_nxt = cmpSrc;
		sarCode_nxt = sarCode_r;
		dout_nxt = 1'b0;
		if (inResult) begin
			sarCode_nxt = decided ? trialCode : sarBase;
			dout_nxt = decided;
		end
		convDone_nxt = convDone_r || (edgeCnt_nxt == `SADC_LSB_EDGE);
	end

	// Link register stage; a high select clears it between frames
	always_ff @(posedge sclk or posedge convSelectN) begin
		if (convSelectN) begin
			edgeCnt_r <= '0;
			holdCap_r <= '0;
			sarCode_r <= '0;
			dout_r <= 1'b0;
			convDone_r <= 1'b0;
		end else begin
			edgeCnt_r <= edgeCnt_nxt;
			holdCap_r <= holdCap_nxt;
			sarCode_r <= sarCode_nxt;
			dout_r <= dout_nxt;
			convDone_r <= convDone_nxt;
		end
	end

	// ==========================================================
	// Pin drivers
	// Drive only inside a frame and only when powered
	assign doutOe = !convSelectN && pdSync_r;
	assign doutData = dout_r;
	// High tracks the input, low holds; holding starts at select fall
	assign hold_capacitor = convSelectN || convDone_r || !pdSync_r;

endmodule

//--- sadc_readout_sva.sv
`timescale 1ns/1ps

module sadc_readout_sva (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic sclk,
	input wire logic convSelectN,
	input wire logic power_down_n,
	input wire logic doutData,
	input wire logic doutOe,
	input wire logic hold_capacitor,
	input wire logic refEnable,
	input wire logic shutdownActive,
	input wire logic acquireSettled
);
	logic [4:0] riseCnt;

	// ==========================================================
	// Link rise counter, cleared while select is high
	always_ff @(posedge sclk or posedge convSelectN) begin
		if (convSelectN) begin
			riseCnt <= 5'h00;
		end else if (riseCnt != 5'h1f) begin
			riseCnt <= riseCnt + 5'h01;
		end
	end

	// ==========================================================
	// Port relations
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	AST_OE_IDLE: assert property (convSelectN |-> !doutOe)
		else $error("output driven while select high");
	AST_OE_FALL: assert property ($fell(convSelectN) && refEnable |-> doutOe && !doutData)
		else $error("output not driven low at select fall");
	AST_OE_POWER_DOWN_N: assert property ((!power_down_n)[*4] |-> !doutOe && hold_capacitor)
		else $error("output or track hold active in shutdown");
	AST_REF_OFF: assert property ((!power_down_n)[*4] |-> !refEnable && shutdownActive)
		else $error("reference on in shutdown");
	AST_REF_ON: assert property (power_down_n[*4] |-> refEnable && !shutdownActive)
		else $error("not in normal mode");
	AST_DOUT_STILL: assert property (!convSelectN && $past(!convSelectN) && $stable(riseCnt) |-> $stable(doutData))
		else $error("output changed without link rise");
	AST_ACQ: assert property ($rose(convSelectN) |-> !acquireSettled[*8] ##[36:44] acquireSettled)
		else $error("acquisition flag timing wrong");
	AST_TH_BUSY: assert property (!convSelectN && refEnable && riseCnt < 5'h0e |-> !hold_capacitor)
		else $error("track hold not holding during conversion");
	AST_TH_DONE: assert property (!convSelectN && riseCnt >= 5'h0e |-> hold_capacitor)
		else $error("track hold not back to tracking");
endmodule

bind sadc_readout sadc_readout_sva sadc_readout_sva_i (.mclk, .nrst, .sclk, .convSelectN,
	.power_down_n, .doutData, .doutOe, .hold_capacitor, .refEnable, .shutdownActive,
	.acquireSettled);

//--- sadc_host_model.sv
`timescale 1ns/1ps

module sadc_host_model (
	output logic sclk,
	output logic convSelectN,
	input wire logic doutData,
	input wire logic doutOe
);
	logic lineLevel;

	// Released line reads as the inverse, no pull on it
	assign lineLevel = doutOe ? doutData : ~doutData;

	// Link clock stands low, select idle high
	initial begin
		sclk = 1'b0;
		convSelectN = 1'b1;
	end

	// ==========================================================
	// One frame: select low, a burst of rises, select high, rest
	task automatic frame(input int rises, output logic [15:0] got);
		got = 16'h0000;
		#3.3 convSelectN = 1'b0;
		#60;
		repeat (rises) begin
			got = {got[14:0], lineLevel};
			sclk = 1'b1;
			#6 sclk = 1'b0;
			#6;
		end
		convSelectN = 1'b1;
		#600;
	endtask
endmodule

//--- sadc_readout_tb.sv
`timescale 1ns/1ps

module testbench;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic power_down_n = 1'b0;
	sadc_pkg::sadcSample_t analog_input = 12'h000;
	logic analogInputValid = 1'b0;
	logic sclk, convSelectN, analogInputReady, doutData, doutOe, hold_capacitor;
	logic refEnable, shutdownActive, acquireSettled, sampleMissed;
	logic [15:0] got;
	int bad_count = 0;
	int checks_done = 0;

	// Clock and parts
	always #5 mclk = ~mclk;
	sadc_readout sadc_readout_i (.mclk, .nrst, .sclk, .convSelectN, .power_down_n, .analog_input,
		.analogInputValid, .analogInputReady, .doutData, .doutOe, .hold_capacitor, .refEnable,
		.shutdownActive, .acquireSettled, .sampleMissed);
	sadc_host_model sadc_host_model_i (.sclk, .convSelectN, .doutData, .doutOe);

	// ==========================================================
	// Shared tasks
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Valid stays up; the caller lowers it after one more edge
	task automatic push(input sadc_pkg::sadcSample_t w);
		@(posedge mclk);
		analog_input <= w;
		analogInputValid <= 1'b1;
	endtask

	task automatic push_end;
		@(posedge mclk);
		analogInputValid <= 1'b0;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_power;
		#1;
		check("refEnable", refEnable, 1'b0);
		check("shutdownActive", shutdownActive, 1'b1);
		check("hold_capacitor", hold_capacitor, 1'b1);
		check("acquireSettled", acquireSettled, 1'b1);
		check("sampleMissed", sampleMissed, 1'b0);
		@(posedge mclk);
		power_down_n <= 1'b1;
		repeat (5) @(posedge mclk);
		#1;
		check("refEnable", refEnable, 1'b1);
		check("shutdownActive", shutdownActive, 1'b0);
		$display("test power done");
	endtask

	task automatic t_stream;
		sadc_pkg::sadcSample_t w [8] = '{12'hfff, 12'h000, 12'ha5c, 12'h801,
			12'h5a3, 12'h001, 12'h7ff, 12'h800};
		for (int k = 0; k < 8; k++) push(w[k]);
		push(12'h3c3);
		push_end;
		check("analogInputReady", analogInputReady, 1'b0);
		for (int k = 0; k < 9; k++) begin
			sadc_host_model_i.frame(16, got);
			check("frame", got, {3'b000, w[k < 8 ? k : 7], 1'b0});
			check("sampleMissed", sampleMissed, k == 8);
		end
		check("hold_capacitor", hold_capacitor, 1'b1);
		check("analogInputReady", analogInputReady, 1'b1);
		$display("test stream done");
	endtask

	task automatic t_shutdown;
		push(12'h6b9);
		push_end;
		power_down_n <= 1'b0;
		repeat (5) @(posedge mclk);
		check("refEnable", refEnable, 1'b0);
		check("shutdownActive", shutdownActive, 1'b1);
		sadc_host_model_i.frame(16, got);
		@(posedge mclk);
		power_down_n <= 1'b1;
		repeat (5) @(posedge mclk);
		sadc_host_model_i.frame(16, got);
		check("frame", got, {3'b000, 12'h6b9, 1'b0});
		check("sampleMissed", sampleMissed, 1'b0);
		$display("test shutdown done");
	endtask

	task automatic t_abort;
		push(12'hc37);
		push(12'h218);
		push_end;
		sadc_host_model_i.frame(5, got);
		check("abort", got, 16'h0003);
		sadc_host_model_i.frame(16, got);
		check("frame", got, {3'b000, 12'h218, 1'b0});
		$display("test abort done");
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		t_power;
		t_stream;
		t_shutdown;
		t_abort;
		test_done;
	end

	initial begin
		#100000;
		bad_count++;
		test_done;
	end
endmodule
